// [include/fp_pkg.sv]
package fp_pkg;

   // ****************
   // Sequencer requests
   // ****************
   typedef enum logic [3:0] {
      OP_LOAD = 4'h0,
      OP_STORE = 4'h1,
      OP_ADD = 4'h2,
      OP_SUB = 4'h3,
      OP_MUL = 4'h4,
      OP_DIV = 4'h5,
      OP_CMP = 4'h6,
      OP_SET_FM = 4'h7,
      OP_CLEAR_FM = 4'h8,
      OP_OTHER = 4'h9
   } op_t;

   // ****************
   // Number format
   // ****************
   localparam logic [15:0] SAVE_PTR_LOC = 16'h0001;
   localparam logic [15:0] OVF_POS_W1 = 16'h7FFF;
   localparam logic [15:0] OVF_POS_W2 = 16'hFFFF;
   localparam logic [15:0] OVF_NEG_W1 = 16'h8000;
   localparam logic [15:0] OVF_NEG_W2 = 16'h0001;
   localparam logic [15:0] OVF_EXP = 16'h7FFF;
   localparam logic signed [18:0] EXP_MAX = 19'sh0_7FFF;
   localparam logic signed [18:0] EXP_MIN = 19'sh7_8000;
   localparam logic signed [18:0] ADD_EXP_ADJ = 19'sh0_0002;
   localparam logic signed [18:0] MUL_EXP_ADJ = 19'sh0_0001;
   localparam logic signed [18:0] DIV_EXP_ADJ = 19'sh0_001F;
   localparam logic [5:0] ADD_SHIFT_CAP = 6'h21;
   localparam logic [6:0] DIV_STEPS = 7'h40;

   // ****************
   // Register map
   // ****************
   localparam logic [7:0] STATUS_OFF = 8'h00;
   localparam logic [7:0] CTRL_OFF = 8'h04;
   localparam int ST_OVF_BIT = 0;
   localparam int ST_CC_O_BIT = 1;
   localparam int ST_CC_C_BIT = 2;
   localparam int ST_BUSY_BIT = 3;
   localparam int ST_FM_BIT = 9;
   localparam int CTRL_OPT_BIT = 0;
   localparam logic CTRL_OPT_RESET = 1'b1;

endpackage : fp_pkg

// [src/fp_normalize.sv]
`timescale 1ns/1ps
module fp_normalize (
   input wire logic [63:0] mn,
   input wire logic signed [18:0] e_in,
   output logic [47:0] res,
   output logic range_err
);
   logic [5:0] sh;
   logic found;
   logic [63:0] sv;
   logic [31:0] m;
   logic signed [18:0] e;

   // Leading-sign shift, truncation, range clamp
   always_comb begin
      sh = 6'h3E;
      found = 1'b0;
      for (int i = 62; i >= 0; i--) begin
         if (!found && mn[i] != mn[63]) begin
            sh = 6'(62 - i);
            found = 1'b1;
         end
      end
      sv = mn << sh;
      m = sv[63:32]; // No guard bits kept
      e = e_in - $signed({13'h0000, sh});
      // Minus one is not normalized: use minus one half
      if (m == 32'h8000_0000) begin
         m = 32'hC000_0000;
         e = e + 19'sh0_0001;
      end
      range_err = 1'b0;
      res = {m, e[15:0]};
      if (mn == 64'h0) begin
         res = 48'h0;
      end else if (e < fp_pkg::EXP_MIN) begin
         res = 48'h0;
         range_err = 1'b1;
      end else if (e > fp_pkg::EXP_MAX) begin
         range_err = 1'b1;
         if (mn[63]) begin
            res = {fp_pkg::OVF_NEG_W1, fp_pkg::OVF_NEG_W2, fp_pkg::OVF_EXP};
         end else begin
            res = {fp_pkg::OVF_POS_W1, fp_pkg::OVF_POS_W2, fp_pkg::OVF_EXP};
         end
      end
   end

endmodule : fp_normalize

// [src/fp_divider.sv]
`timescale 1ns/1ps
module fp_divider (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic start,
   input wire logic [31:0] num_mag,
   input wire logic [31:0] den_mag,
   output logic done,
   output logic [63:0] quot
);
   logic [6:0] cnt_reg;
   logic [31:0] rem_reg;
   logic [33:0] trial;

   // Restoring step; remainder stays below the divisor
   assign trial = {1'b0, rem_reg, quot[63]} - {2'b00, den_mag};

   // One quotient bit a cycle, trading speed for area
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= 7'h00;
         rem_reg <= 32'h0000_0000;
         quot <= 64'h0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            cnt_reg <= fp_pkg::DIV_STEPS;
            rem_reg <= 32'h0000_0000;
            quot <= {num_mag, 32'h0000_0000};
         end else if (cnt_reg != 7'h00) begin
            if (!trial[33]) begin
               rem_reg <= trial[31:0];
               quot <= {quot[62:0], 1'b1};
            end else begin
               rem_reg <= {rem_reg[30:0], quot[63]};
               quot <= {quot[62:0], 1'b0};
            end
            cnt_reg <= cnt_reg - 7'h01;
            done <= (cnt_reg == 7'h01);
         end
      end
   end

endmodule : fp_divider

// [src/float_mode_arith_unit.sv]
`timescale 1ns/1ps
module float_mode_arith_unit (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic op_valid,
   input wire logic [3:0] op_code,
   input wire logic [15:0] op_ea,
   input wire logic [3:0] address_modifier_bits,
   output logic op_done,
   output logic float_mode_flag,
   output logic acc_we,
   output logic [15:0] acc_data,
   output logic ovf_ind,
   output logic cc_o,
   output logic cc_c,
   output logic machine_fault,
   output logic mem_req,
   output logic mem_we,
   output logic [15:0] mem_addr,
   output logic [15:0] mem_wdata,
   input wire logic mem_ack,
   input wire logic [15:0] mem_rdata
);
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_PTR = 3'b001,
      S_RD = 3'b010,
      S_EXEC = 3'b011,
      S_DIVW = 3'b100,
      S_WR = 3'b101,
      S_DONE = 3'b110
   } state_t;

   state_t state_reg;
   fp_pkg::op_t kind_reg;
   logic [1:0] idx_reg;
   logic [15:0] base_reg;
   logic [47:0] opnd_reg;
   logic [47:0] sfa_reg;
   logic fm_reg, ovf_reg, cc_o_reg, cc_c_reg, opt_reg, fault_reg, acc_we_reg;
   logic [15:0] acc_reg;
   logic accept, is_float, set_req, set_ok, last_word, arith_op, div_start, div_done;
   logic signed [31:0] ma, mb;
   logic signed [18:0] ea, eb, ea_x, eb_x, e_big, ediff, norm_e;
   logic signed [32:0] a33, b33, a_al, b_al;
   logic [5:0] shf;
   logic signed [33:0] sum;
   logic signed [63:0] prod;
   logic [63:0] quot, div_mn, norm_mn;
   logic [47:0] norm_res;
   logic norm_err;

   // ****************
   // Request decode
   // ****************
   assign accept = (state_reg == S_IDLE) && op_valid;
   assign is_float = (op_code <= fp_pkg::OP_CMP);
   assign set_req = accept && (op_code == fp_pkg::OP_SET_FM) && (address_modifier_bits == 4'h0);
   assign set_ok = set_req && opt_reg && !fm_reg;
   assign last_word = (idx_reg == 2'h2);
   assign arith_op = (kind_reg >= fp_pkg::OP_ADD) && (kind_reg <= fp_pkg::OP_DIV);

   // ****************
   // Sequencer
   // ****************
   // Operand words go out in order, first word at the effective address
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= S_IDLE;
         kind_reg <= fp_pkg::OP_OTHER;
         idx_reg <= 2'h0;
         base_reg <= 16'h0000;
      end else begin
         unique case (state_reg)
            S_IDLE: begin
               if (op_valid) begin
                  kind_reg <= fp_pkg::op_t'(op_code);
                  base_reg <= op_ea;
                  idx_reg <= 2'h0;
                  if (set_ok || (op_code == fp_pkg::OP_CLEAR_FM && fm_reg)) begin
                     state_reg <= S_PTR;
                  end else if (is_float && fm_reg) begin
                     state_reg <= (op_code == fp_pkg::OP_STORE) ? S_WR : S_RD;
                  end else begin
                     state_reg <= S_DONE;
                  end
               end
            end
            S_PTR: begin
               if (mem_ack) begin
                  base_reg <= mem_rdata;
                  state_reg <= (kind_reg == fp_pkg::OP_SET_FM) ? S_RD : S_WR;
               end
            end
            S_RD: begin
               if (mem_ack) begin
                  idx_reg <= idx_reg + 2'h1;
                  if (last_word) begin
                     state_reg <= S_EXEC;
                  end
               end
            end
            S_EXEC: begin
               state_reg <= div_start ? S_DIVW : S_DONE;
            end
            S_DIVW: begin
               if (div_done) begin
                  state_reg <= S_DONE;
               end
            end
            S_WR: begin
               if (mem_ack) begin
                  idx_reg <= idx_reg + 2'h1;
                  if (last_word) begin
                     state_reg <= S_DONE;
                  end
               end
            end
            S_DONE: begin
               state_reg <= S_IDLE;
            end
            default: begin
               state_reg <= S_IDLE;
            end
         endcase
      end
   end

   // Memory port; only the write phase drives mem_we
   assign mem_req = (state_reg == S_PTR) || (state_reg == S_RD) || (state_reg == S_WR);
   assign mem_we = (state_reg == S_WR);
   assign mem_addr = (state_reg == S_PTR) ? fp_pkg::SAVE_PTR_LOC : base_reg + {14'h0000, idx_reg};
   assign mem_wdata = (idx_reg == 2'h0) ? sfa_reg[47:32] :
                      (idx_reg == 2'h1) ? sfa_reg[31:16] : sfa_reg[15:0];
   assign op_done = (state_reg == S_DONE);

   // Operand words shift in, first word ends on top
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         opnd_reg <= 48'h0;
      end else if (state_reg == S_RD && mem_ack) begin
         opnd_reg <= {opnd_reg[31:0], mem_rdata};
      end
   end

   // ****************
   // Mode flag
   // ****************
   // Reset clears the flag without any save, as the sequencer is idle then
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fm_reg <= 1'b0;
         fault_reg <= 1'b0;
      end else begin
         fault_reg <= set_req && !opt_reg;
         if (set_ok) begin
            fm_reg <= 1'b1;
         end else if (accept && op_code == fp_pkg::OP_CLEAR_FM) begin
            fm_reg <= 1'b0;
         end
      end
   end
   assign float_mode_flag = fm_reg;
   assign machine_fault = fault_reg;

   // ****************
   // Arithmetic
   // ****************
   // Zero carries no exponent weight, so it adopts the other one
   always_comb begin
      ma = sfa_reg[47:16];
      mb = opnd_reg[47:16];
      ea = {{3{sfa_reg[15]}}, sfa_reg[15:0]};
      eb = {{3{opnd_reg[15]}}, opnd_reg[15:0]};
      ea_x = (ma == 32'h0000_0000) ? eb : ea;
      eb_x = (mb == 32'h0000_0000) ? ea : eb;
      a33 = {ma[31], ma};
      b33 = {mb[31], mb};
      if (kind_reg == fp_pkg::OP_SUB || kind_reg == fp_pkg::OP_CMP) begin
         b33 = -b33;
      end
      ediff = (ea_x >= eb_x) ? ea_x - eb_x : eb_x - ea_x;
      shf = (ediff > $signed({13'h0000, fp_pkg::ADD_SHIFT_CAP})) ? fp_pkg::ADD_SHIFT_CAP : ediff[5:0];
      // Prealignment drops bits shifted off the right
      if (ea_x >= eb_x) begin
         e_big = ea_x;
         a_al = a33;
         b_al = b33 >>> shf;
      end else begin
         e_big = eb_x;
         a_al = a33 >>> shf;
         b_al = b33;
      end
      sum = {a_al[32], a_al} + {b_al[32], b_al};
   end

   assign prod = ma * mb;
   assign div_start = (state_reg == S_EXEC) && (kind_reg == fp_pkg::OP_DIV) && (mb != 32'h0000_0000);
   assign div_mn = (ma[31] ^ mb[31]) ? (~quot + 64'h1) : quot;

   fp_divider u_div (
      .pclk(pclk),
      .presetn(presetn),
      .start(div_start),
      .num_mag(ma[31] ? -ma : ma),
      .den_mag(mb[31] ? -mb : mb),
      .done(div_done),
      .quot(quot)
   );

   // Result scale selected by the pending operation
   always_comb begin
      if (kind_reg == fp_pkg::OP_MUL) begin
         norm_mn = prod;
         norm_e = ea + eb + fp_pkg::MUL_EXP_ADJ;
      end else if (kind_reg == fp_pkg::OP_DIV) begin
         norm_mn = div_mn;
         norm_e = ea - eb + fp_pkg::DIV_EXP_ADJ;
      end else begin
         norm_mn = {sum, 30'h0000_0000};
         norm_e = e_big + fp_pkg::ADD_EXP_ADJ;
      end
   end

   fp_normalize u_norm (
      .mn(norm_mn),
      .e_in(norm_e),
      .res(norm_res),
      .range_err(norm_err)
   );

   // ****************
   // Float accumulator and indicators
   // ****************
   // Only float operations and the mode set reach these registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sfa_reg <= 48'h0;
      end else if (state_reg == S_EXEC) begin
         if (kind_reg == fp_pkg::OP_LOAD || kind_reg == fp_pkg::OP_SET_FM) begin
            sfa_reg <= opnd_reg;
         end else if (kind_reg == fp_pkg::OP_DIV && !div_start) begin
            sfa_reg <= ma[31] ? {fp_pkg::OVF_NEG_W1, fp_pkg::OVF_NEG_W2, fp_pkg::OVF_EXP} :
                       {fp_pkg::OVF_POS_W1, fp_pkg::OVF_POS_W2, fp_pkg::OVF_EXP};
         end else if (arith_op && kind_reg != fp_pkg::OP_DIV) begin
            sfa_reg <= norm_res;
         end
      end else if (state_reg == S_DIVW && div_done) begin
         sfa_reg <= norm_res;
      end
   end

   // Overflow covers both range errors; compare leaves it alone
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovf_reg <= 1'b0;
      end else if (state_reg == S_EXEC && arith_op) begin
         ovf_reg <= div_start ? ovf_reg : (kind_reg == fp_pkg::OP_DIV) || norm_err;
      end else if (state_reg == S_DIVW && div_done) begin
         ovf_reg <= norm_err;
      end
   end

   // Compare codes: less 00, greater 10, equal 11
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cc_o_reg <= 1'b0;
         cc_c_reg <= 1'b0;
      end else if (state_reg == S_EXEC && kind_reg == fp_pkg::OP_CMP) begin
         cc_o_reg <= !sum[33];
         cc_c_reg <= (sum == 34'h0_0000_0000);
      end
   end

   // First word mirrored into general register 7 after load, add, subtract and store
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_we_reg <= 1'b0;
         acc_reg <= 16'h0000;
      end else begin
         acc_we_reg <= 1'b0;
         if (state_reg == S_EXEC && kind_reg == fp_pkg::OP_LOAD) begin
            acc_we_reg <= 1'b1;
            acc_reg <= opnd_reg[47:32];
         end else if (state_reg == S_EXEC && (kind_reg == fp_pkg::OP_ADD || kind_reg == fp_pkg::OP_SUB)) begin
            acc_we_reg <= 1'b1;
            acc_reg <= norm_res[47:32];
         end else if (state_reg == S_WR && mem_ack && last_word && kind_reg == fp_pkg::OP_STORE) begin
            acc_we_reg <= 1'b1;
            acc_reg <= sfa_reg[47:32];
         end
      end
   end
   assign acc_we = acc_we_reg;
   assign acc_data = acc_reg;
   assign ovf_ind = ovf_reg;
   assign cc_o = cc_o_reg;
   assign cc_c = cc_c_reg;

   // ****************
   // APB slave
   // ****************
   // Zero wait states; unmapped offsets answer with an error
   assign pready = 1'b1;
   assign pslverr = psel && penable && (paddr != fp_pkg::STATUS_OFF) && (paddr != fp_pkg::CTRL_OFF);

   always_comb begin
      prdata = 32'h0000_0000;
      if (psel && paddr == fp_pkg::STATUS_OFF) begin
         prdata[fp_pkg::ST_OVF_BIT] = ovf_reg;
         prdata[fp_pkg::ST_CC_O_BIT] = cc_o_reg;
         prdata[fp_pkg::ST_CC_C_BIT] = cc_c_reg;
         prdata[fp_pkg::ST_BUSY_BIT] = (state_reg != S_IDLE);
         prdata[fp_pkg::ST_FM_BIT] = fm_reg;
      end else if (psel && paddr == fp_pkg::CTRL_OFF) begin
         prdata[fp_pkg::CTRL_OPT_BIT] = opt_reg;
      end
   end

   // Option-installed bit gates every attempt to enter float mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         opt_reg <= fp_pkg::CTRL_OPT_RESET;
      end else if (psel && penable && pwrite && paddr == fp_pkg::CTRL_OFF) begin
         opt_reg <= pwdata[fp_pkg::CTRL_OPT_BIT];
      end
   end

   // ****************
   // Checks
   // ****************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_fault_no_mode: assert property (set_req && !opt_reg && !fm_reg |=> machine_fault && !float_mode_flag)
      else $error("mode set without option");
   a_modifier_zero: assert property (accept && op_code == fp_pkg::OP_SET_FM && address_modifier_bits != 4'h0
      |=> float_mode_flag == $past(fm_reg))
      else $error("nonzero modifier changed mode");
   a_fixed_passes: assert property (accept && is_float && !fm_reg && op_code != fp_pkg::OP_SET_FM
      |=> op_done ##1 !mem_req)
      else $error("float op ran outside float mode");
   a_first_addr: assert property (state_reg == S_RD && idx_reg == 2'h0 |-> mem_addr == base_reg)
      else $error("operand not at effective address");
   a_only_write: assert property (mem_req && mem_we |-> state_reg == S_WR && mem_wdata ==
      (idx_reg == 2'h0 ? sfa_reg[47:32] : idx_reg == 2'h1 ? sfa_reg[31:16] : sfa_reg[15:0]))
      else $error("bad store word");
   a_cmp_keeps: assert property (state_reg == S_EXEC && kind_reg == fp_pkg::OP_CMP
      |=> $stable(sfa_reg) && !mem_we)
      else $error("compare modified state");
   a_zero_form: assert property (norm_res[47:16] == 32'h0000_0000 |-> norm_res[15:0] == 16'h0000)
      else $error("zero with exponent");
   // Minus one half is the one normalized negative whose two top bits agree
   a_normal_form: assert property (norm_res[47:16] != 32'h0000_0000 |-> (norm_res[47] != norm_res[46]
      && norm_res[47:16] != 32'h8000_0000) || norm_res[47:16] == 32'hC000_0000)
      else $error("unnormalized result");
   a_ovf_flag: assert property (state_reg == S_EXEC && arith_op && kind_reg != fp_pkg::OP_DIV
      |=> ovf_ind == $past(norm_err))
      else $error("overflow flag wrong");
   a_div_zero: assert property (state_reg == S_EXEC && kind_reg == fp_pkg::OP_DIV && mb == 32'h0000_0000
      |=> ovf_ind && sfa_reg[15:0] == fp_pkg::OVF_EXP && op_done)
      else $error("divide by zero not overflow");
   a_acc_copy: assert property (state_reg == S_EXEC && kind_reg == fp_pkg::OP_LOAD
      |=> acc_we && acc_data == $past(opnd_reg[47:32]))
      else $error("register 7 not updated");
   a_save_clear: assert property (accept && op_code == fp_pkg::OP_CLEAR_FM && fm_reg
      |=> !float_mode_flag && mem_req && mem_addr == fp_pkg::SAVE_PTR_LOC)
      else $error("no save on mode clear");

   c_store: cover property (state_reg == S_WR && mem_ack && last_word && kind_reg == fp_pkg::OP_STORE);
   c_divide: cover property (state_reg == S_DIVW && div_done);
   c_fault: cover property (machine_fault);
   c_save: cover property (op_done && kind_reg == fp_pkg::OP_CLEAR_FM && !float_mode_flag);

endmodule : float_mode_arith_unit

// [test/fp_mem_model.sv]
`timescale 1ns/1ps
// ****************
// Memory partner
// ****************
module fp_mem_model (
   input wire logic pclk,
   input wire logic slow,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [15:0] mem_addr,
   input wire logic [15:0] mem_wdata,
   output logic mem_ack,
   output logic [15:0] mem_rdata
);
   logic [15:0] mem [0:255];
   logic [1:0] wait_cnt = 2'h0;
   logic [15:0] last_q = 16'h0000;
   // Slow mode answers on the third cycle of a request
   assign mem_ack = mem_req && (wait_cnt == (slow ? 2'h2 : 2'h0));
   // Inverse of last word when not acked, so a stale read cannot pass
   assign mem_rdata = (mem_ack && !mem_we) ? mem[mem_addr[7:0]] : ~last_q;
   // One word moves per acked edge
   always @(posedge pclk) begin
      if (mem_ack) begin
         wait_cnt <= 2'h0;
         if (mem_we) mem[mem_addr[7:0]] <= mem_wdata;
         else last_q <= mem[mem_addr[7:0]];
      end else if (mem_req) begin
         wait_cnt <= wait_cnt + 2'h1;
      end
   end
endmodule : fp_mem_model

// [test/testbench.sv]
`timescale 1ns/1ps
module testbench;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, op_valid = 0, slow = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, q;
   logic [3:0] op_code = 4'h9, amb = 4'h0;
   logic [15:0] op_ea = 16'h0000, acc_data, mem_addr, mem_wdata, mem_rdata, last_acc;
   logic pready, pslverr, op_done, fm, acc_we, ovf_ind, cc_o, cc_c, mf, mem_req, mem_we, mem_ack, err;
   logic fault_seen = 0;
   int mismatches = 0, total_checks = 0;
   float_mode_arith_unit i_float_mode_arith_unit (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .op_valid(op_valid), .op_code(op_code), .op_ea(op_ea),
      .address_modifier_bits(amb), .op_done(op_done), .float_mode_flag(fm), .acc_we(acc_we),
      .acc_data(acc_data), .ovf_ind(ovf_ind), .cc_o(cc_o), .cc_c(cc_c), .machine_fault(mf),
      .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   fp_mem_model i_fp_mem_model (.pclk(pclk), .slow(slow), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   // Clock and pulse catchers; pulses last one cycle only
   always #2.5 pclk = ~pclk;
   always @(posedge pclk) begin
      if (mf) fault_seen <= 1'b1;
      if (acc_we) last_acc <= acc_data;
   end
   // ****************
   // Shared tasks
   // ****************
   task automatic cmp(input string what, input logic [47:0] exp, input logic [47:0] got);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp
   // Waits for the slave as long as it takes; only the watchdog ends a hang
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 0; penable <= 0;
   endtask : apb
   task automatic op(input logic [3:0] c, input logic [15:0] ea, input logic [3:0] m);
      int n;
      n = 0;
      @(posedge pclk);
      op_valid <= 1; op_code <= c; op_ea <= ea; amb <= m;
      @(posedge pclk);
      op_valid <= 0;
      while (op_done !== 1'b1 && n < 300) begin
         @(posedge pclk);
         n++;
      end
      // One more edge so pulse catchers and memory writes have settled
      @(posedge pclk);
      if (n >= 300) cmp("op_done", 1, 0);
   endtask : op
   // Operand at 16, accumulator read back by a store to 48
   task automatic fop(input logic [3:0] c, input logic [47:0] opnd, input logic [47:0] exp, input logic [1:0] eo);
      {i_fp_mem_model.mem[16], i_fp_mem_model.mem[17], i_fp_mem_model.mem[18]} = opnd;
      op(c, 16'h0010, 4'h0);
      op(fp_pkg::OP_STORE, 16'h0030, 4'h0);
      cmp("accumulator", exp, {i_fp_mem_model.mem[48], i_fp_mem_model.mem[49], i_fp_mem_model.mem[50]});
      cmp("operand", opnd, {i_fp_mem_model.mem[16], i_fp_mem_model.mem[17], i_fp_mem_model.mem[18]});
      if (eo[1]) cmp("overflow", eo[0], ovf_ind);
   endtask : fop
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up
   // ****************
   // Scenarios
   // ****************
   task automatic mode_setup;
      apb(0, 8'h00, 0);
      cmp("status", 0, q);
      apb(0, 8'h08, 0);
      cmp("unmapped error", 1, err);
      {i_fp_mem_model.mem[16], i_fp_mem_model.mem[17], i_fp_mem_model.mem[18]} = 48'h4000_0000_0001;
      op(fp_pkg::OP_LOAD, 16'h0010, 4'h0);
      cmp("flag", 0, fm);
      apb(1, 8'h04, 0);
      op(fp_pkg::OP_SET_FM, 16'h0000, 4'h0);
      cmp("fault", 1, fault_seen);
      cmp("flag", 0, fm);
      apb(1, 8'h04, 1);
      i_fp_mem_model.mem[1] = 16'h0040;
      {i_fp_mem_model.mem[64], i_fp_mem_model.mem[65], i_fp_mem_model.mem[66]} = 48'h5000_0000_0004;
      op(fp_pkg::OP_SET_FM, 16'h0000, 4'h1);
      cmp("flag", 0, fm);
      op(fp_pkg::OP_SET_FM, 16'h0000, 4'h0);
      cmp("flag", 1, fm);
      apb(0, 8'h00, 0);
      cmp("status", 1, q[9]);
   endtask : mode_setup
   task automatic arith;
      fop(fp_pkg::OP_CMP, 48'h5000_0000_0004, 48'h5000_0000_0004, 0);
      cmp("cc", 2'b11, {cc_o, cc_c});
      fop(fp_pkg::OP_CMP, 48'h6400_0000_0007, 48'h5000_0000_0004, 0);
      cmp("cc", 2'b00, {cc_o, cc_c});
      fop(fp_pkg::OP_CMP, 48'hB000_0000_0004, 48'h5000_0000_0004, 0);
      cmp("cc", 2'b10, {cc_o, cc_c});
      fop(fp_pkg::OP_LOAD, 48'h5000_0000_0004, 48'h5000_0000_0004, 0);
      cmp("register 7", 16'h5000, last_acc);
      fop(fp_pkg::OP_ADD, 48'h5000_0000_0004, 48'h5000_0000_0005, 2'b10);
      slow <= 1'b1;
      fop(fp_pkg::OP_SUB, 48'h5000_0000_0005, 0, 2'b10);
      fop(fp_pkg::OP_LOAD, 48'h5000_0000_0004, 48'h5000_0000_0004, 0);
      fop(fp_pkg::OP_MUL, 48'h5000_0000_0004, 48'h6400_0000_0007, 2'b10);
      fop(fp_pkg::OP_DIV, 48'h5000_0000_0004, 48'h5000_0000_0004, 2'b10);
      fop(fp_pkg::OP_LOAD, 48'h4000_0000_7FFF, 48'h4000_0000_7FFF, 0);
      fop(fp_pkg::OP_ADD, 48'h4000_0000_7FFF, 48'h7FFF_FFFF_7FFF, 2'b11);
      slow <= 1'b0;
      fop(fp_pkg::OP_LOAD, 48'hC000_0000_0001, 48'hC000_0000_0001, 0);
      fop(fp_pkg::OP_DIV, 0, 48'h8000_0001_7FFF, 2'b11);
      fop(fp_pkg::OP_LOAD, 48'h4000_0000_8000, 48'h4000_0000_8000, 0);
      fop(fp_pkg::OP_MUL, 48'h4000_0000_8000, 0, 2'b11);
      fop(fp_pkg::OP_LOAD, 48'h8000_0000_0000, 48'h8000_0000_0000, 0);
      fop(fp_pkg::OP_ADD, 0, 48'hC000_0000_0001, 2'b10);
      op(fp_pkg::OP_CLEAR_FM, 16'h0000, 4'h0);
      cmp("flag", 0, fm);
      cmp("save", 48'hC000_0000_0001, {i_fp_mem_model.mem[64], i_fp_mem_model.mem[65], i_fp_mem_model.mem[66]});
   endtask : arith
   // Main sequence
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1;
      mode_setup();
      arith();
      wrap_up();
   end
   // Watchdog
   initial begin
      #200000;
      mismatches++;
      wrap_up();
   end
endmodule : testbench
